// ### hw/svd_ctrl.v
// Supply voltage detector control logic with Wishbone register slave
//
// Overview of operation
// - Mode and thresholds come from the option byte, not from run-time registers.
// - Detection threshold is one of twelve levels chosen by an option byte field.
// - Mode field 1,0 is interrupt-and-reset, 1,1 reset-only, 0,1 interrupt.
// - Supply is compared to thresholds; mode decides reset request, interrupt, or both.
// - Combined: interrupt below upper, reset below lower, release at or above upper.
// - Reset-only: reset while below the threshold, release at or above it.
// - Interrupt mode: hold reset after reset until supply first reaches threshold.
// - Interrupt mode after release: interrupt on every threshold crossing, both directions.
// - Current comparison result is readable in bit 0 of the detection register.
// - A detector-caused reset sets bit 0 of the reset cause register.
//
// Added by the designer: the placing of the registers and register access over Wishbone.
`timescale 1ns/10ps
`default_nettype none
`include "svd_regs.vh"

module svd_ctrl #(
    parameter ADDR_W = 8
) (
    input wire i_core_clk,
    input wire i_rst,
    // Wishbone classic slave
    input wire i_wb_cyc,
    input wire i_wb_stb,
    input wire i_wb_we,
    input wire [ADDR_W-1:0] i_wb_adr,
    input wire [31:0] i_wb_dat,
    input wire [3:0] i_wb_sel,
    output reg [31:0] o_wb_dat,
    output reg o_wb_ack,
    // Option byte and analog side
    input wire [7:0] i_opt_byte,
    input wire i_cmp_upper,
    input wire i_cmp_lower,
    output reg [19:0] o_opt_addr,
    output reg o_detect_en,
    output reg [3:0] o_level_sel,
    // Results
    output reg o_int_reset,
    output reg o_supply_level_irq,
    output reg o_irq
);

    // --------------------------------------------------------------------
    // State codes
    // --------------------------------------------------------------------
    localparam [1:0] ST_OFF = 2'h0;
    localparam [1:0] ST_HOLD = 2'h1;
    localparam [1:0] ST_RUN = 2'h2;

    // --------------------------------------------------------------------
    // Declarations
    // --------------------------------------------------------------------
    reg cfg_loaded;
    reg [7:0] opt_cfg;
    wire [1:0] cmp_sync;
    wire above_upper;
    wire above_lower;
    reg above_upper_d;
    reg [1:0] state;
    reg [1:0] next_state;
    reg level_evt;
    reg reset_evt;
    wire [1:0] det_mode;
    wire [3:0] raw_level;
    wire [3:0] det_level;
    wire mode_valid;
    wire below_flag;
    reg [`SVD_EVT_W-1:0] irq_status;
    reg [`SVD_EVT_W-1:0] irq_enable;
    reg [`SVD_EVT_W-1:0] next_status;
    reg [`SVD_EVT_W-1:0] next_enable;
    reg [`SVD_EVT_W-1:0] clr_mask;
    reg detector_reset_cause;
    reg next_cause;
    wire bus_req;
    wire bus_wr;
    wire bus_rd;
    wire [ADDR_W-1:0] word_adr;
    reg [31:0] next_rdata;
    wire [31:0] detect_ctrl_reg;
    wire [31:0] reset_cause_reg;
    wire [1:0] opt_mode_now;
    wire hold_at_load;

    // --------------------------------------------------------------------
    // Option byte capture
    // --------------------------------------------------------------------
    always @(posedge i_core_clk) begin
        if (i_rst) begin
            cfg_loaded <= 1'b0;
            opt_cfg <= `SVD_RST_OPT;
        end else if (!cfg_loaded) begin
            cfg_loaded <= 1'b1;
            opt_cfg <= i_opt_byte;
        end
    end

    assign det_mode = {opt_cfg[`SVD_OPT_MODE_HI], opt_cfg[`SVD_OPT_MODE_LO]};
    assign raw_level = opt_cfg[`SVD_OPT_LEVEL_MSB:`SVD_OPT_LEVEL_LSB];
    assign det_level = (raw_level < `SVD_LEVEL_COUNT) ? raw_level : `SVD_LEVEL_MAX;
    assign mode_valid = cfg_loaded && (det_mode != `SVD_MODE_OFF);

    // Keeps reset held across the capture cycle so it never dips after release
    assign opt_mode_now = {i_opt_byte[`SVD_OPT_MODE_HI], i_opt_byte[`SVD_OPT_MODE_LO]};
    assign hold_at_load = !cfg_loaded && (opt_mode_now != `SVD_MODE_OFF);

    // --------------------------------------------------------------------
    // Comparator synchroniser
    // --------------------------------------------------------------------
    svd_sync2 #(
        .WIDTH(2)
    ) u_cmp_sync (
        .i_core_clk(i_core_clk),
        .i_rst(i_rst),
        .i_async({i_cmp_lower, i_cmp_upper}),
        .o_sync(cmp_sync)
    );

    assign above_upper = cmp_sync[0];
    assign above_lower = cmp_sync[1];

    // --------------------------------------------------------------------
    // Detection state machine
    // --------------------------------------------------------------------
    always @* begin
        next_state = state;
        level_evt = 1'b0;
        case (state)
            ST_OFF: begin
                if (mode_valid) begin
                    next_state = ST_HOLD;
                end
            end
            ST_HOLD: begin
                if (above_upper) begin
                    next_state = ST_RUN;
                end
            end
            ST_RUN: begin
                case (det_mode)
                    `SVD_MODE_IRQ_RST: begin
                        if (above_upper_d && !above_upper) begin
                            level_evt = 1'b1;
                        end
                        if (!above_lower) begin
                            next_state = ST_HOLD;
                        end
                    end
                    `SVD_MODE_RST: begin
                        if (!above_upper) begin
                            next_state = ST_HOLD;
                        end
                    end
                    `SVD_MODE_IRQ: begin
                        if (above_upper_d != above_upper) begin
                            level_evt = 1'b1;
                        end
                    end
                    default: begin
                        next_state = ST_OFF;
                    end
                endcase
            end
            default: begin
                next_state = ST_OFF;
            end
        endcase
        reset_evt = (state == ST_RUN) && (next_state == ST_HOLD);
    end

    always @(posedge i_core_clk) begin
        if (i_rst) begin
            state <= ST_OFF;
            above_upper_d <= 1'b0;
            o_int_reset <= 1'b1;
            o_supply_level_irq <= 1'b0;
        end else begin
            state <= next_state;
            above_upper_d <= above_upper;
            o_int_reset <= (next_state == ST_HOLD) || hold_at_load;
            o_supply_level_irq <= level_evt;
        end
    end

    // --------------------------------------------------------------------
    // Analog side configuration outputs
    // --------------------------------------------------------------------
    always @(posedge i_core_clk) begin
        if (i_rst) begin
            o_opt_addr <= `SVD_OPT_ADDR;
            o_detect_en <= 1'b0;
            o_level_sel <= 4'h0;
        end else begin
            o_opt_addr <= `SVD_OPT_ADDR;
            o_detect_en <= mode_valid;
            o_level_sel <= det_level;
        end
    end

    // --------------------------------------------------------------------
    // Readable register images
    // --------------------------------------------------------------------
    assign below_flag = (state != ST_OFF) && !above_upper;

    assign detect_ctrl_reg = {
        20'h00000,
        det_level,
        2'h0,
        det_mode,
        (state == ST_HOLD),
        2'h0,
        below_flag
    };

    assign reset_cause_reg = {31'h00000000, detector_reset_cause};

    // --------------------------------------------------------------------
    // Wishbone decode
    // --------------------------------------------------------------------
    assign bus_req = i_wb_cyc && i_wb_stb;
    assign bus_wr = bus_req && i_wb_we && o_wb_ack && i_wb_sel[0];
    assign bus_rd = bus_req && !i_wb_we && o_wb_ack;
    assign word_adr = {i_wb_adr[ADDR_W-1:2], 2'b00};

    always @* begin
        next_rdata = 32'h00000000;
        case (word_adr)
            `SVD_ADR_DETECT_CTRL: begin
                next_rdata = detect_ctrl_reg;
            end
            `SVD_ADR_RESET_CAUSE: begin
                next_rdata = reset_cause_reg;
            end
            `SVD_ADR_IRQ_STATUS: begin
                next_rdata = {30'h00000000, irq_status};
            end
            `SVD_ADR_IRQ_ENABLE: begin
                next_rdata = {30'h00000000, irq_enable};
            end
            default: begin
                next_rdata = 32'h00000000;
            end
        endcase
    end

    always @(posedge i_core_clk) begin
        if (i_rst) begin
            o_wb_ack <= 1'b0;
            o_wb_dat <= 32'h00000000;
        end else begin
            o_wb_ack <= bus_req && !o_wb_ack;
            if (bus_req && !o_wb_ack && !i_wb_we) begin
                o_wb_dat <= next_rdata;
            end
        end
    end

    // --------------------------------------------------------------------
    // Interrupt status, enable and clear
    // --------------------------------------------------------------------
    always @* begin
        clr_mask = {`SVD_EVT_W{1'b0}};
        next_enable = irq_enable;
        if (bus_wr && (word_adr == `SVD_ADR_IRQ_CLEAR)) begin
            clr_mask = i_wb_dat[`SVD_EVT_W-1:0];
        end
        if (bus_wr && (word_adr == `SVD_ADR_IRQ_ENABLE)) begin
            next_enable = i_wb_dat[`SVD_EVT_W-1:0];
        end
        next_status = irq_status & ~clr_mask;
        next_status[`SVD_EVT_LEVEL_BIT] = next_status[`SVD_EVT_LEVEL_BIT] | level_evt;
        next_status[`SVD_EVT_RESET_BIT] = next_status[`SVD_EVT_RESET_BIT] | reset_evt;
    end

    // --------------------------------------------------------------------
    // Reset cause, cleared by a read that returned it set
    // --------------------------------------------------------------------
    always @* begin
        next_cause = detector_reset_cause;
        if (bus_rd && (word_adr == `SVD_ADR_RESET_CAUSE) && o_wb_dat[`SVD_CAUSE_DET_BIT]) begin
            next_cause = 1'b0;
        end
        if (reset_evt) begin
            next_cause = 1'b1;
        end
    end

    always @(posedge i_core_clk) begin
        if (i_rst) begin
            irq_status <= `SVD_RST_IRQ_STATUS;
            irq_enable <= `SVD_RST_IRQ_ENABLE;
            detector_reset_cause <= `SVD_RST_CAUSE;
            o_irq <= 1'b0;
        end else begin
            irq_status <= next_status;
            irq_enable <= next_enable;
            detector_reset_cause <= next_cause;
            o_irq <= |(next_status & next_enable);
        end
    end

endmodule // svd_ctrl

`default_nettype wire

// ### hw/svd_regs.vh
// Constants for the supply voltage detector control block
`ifndef SVD_REGS_VH
`define SVD_REGS_VH

// ----------------------------------------------------------------------------
// Configuration option byte
// ----------------------------------------------------------------------------
`define SVD_OPT_ADDR 20'h000C1
`define SVD_OPT_LEVEL_LSB 0
`define SVD_OPT_LEVEL_MSB 3
`define SVD_OPT_MODE_LO 4
`define SVD_OPT_MODE_HI 5
`define SVD_LEVEL_COUNT 4'hC
`define SVD_LEVEL_MAX 4'hB

// ----------------------------------------------------------------------------
// Mode codes {detect_mode_sel_hi, detect_mode_sel_lo}
// ----------------------------------------------------------------------------
`define SVD_MODE_OFF 2'h0
`define SVD_MODE_IRQ 2'h1
`define SVD_MODE_IRQ_RST 2'h2
`define SVD_MODE_RST 2'h3

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define SVD_ADR_DETECT_CTRL 8'h00
`define SVD_ADR_RESET_CAUSE 8'h04
`define SVD_ADR_IRQ_STATUS 8'h08
`define SVD_ADR_IRQ_ENABLE 8'h0C
`define SVD_ADR_IRQ_CLEAR 8'h10

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define SVD_DET_BELOW_BIT 0
`define SVD_DET_RESET_BIT 3
`define SVD_DET_MODE_LSB 4
`define SVD_DET_LEVEL_LSB 8
`define SVD_CAUSE_DET_BIT 0
`define SVD_EVT_LEVEL_BIT 0
`define SVD_EVT_RESET_BIT 1
`define SVD_EVT_W 2

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define SVD_RST_IRQ_STATUS 2'h0
`define SVD_RST_IRQ_ENABLE 2'h0
`define SVD_RST_CAUSE 1'h0
`define SVD_RST_OPT 8'h00

`endif

// ### hw/svd_sync2.v
// Two-stage synchroniser for asynchronous level inputs
`timescale 1ns/10ps
`default_nettype none

module svd_sync2 #(
    parameter WIDTH = 2
) (
    input wire i_core_clk,
    input wire i_rst,
    input wire [WIDTH-1:0] i_async,
    output reg [WIDTH-1:0] o_sync
);

    reg [WIDTH-1:0] stage1;

    // --------------------------------------------------------------------
    // Synchroniser stages
    // --------------------------------------------------------------------
    always @(posedge i_core_clk) begin
        if (i_rst) begin
            stage1 <= {WIDTH{1'b0}};
            o_sync <= {WIDTH{1'b0}};
        end else begin
            stage1 <= i_async;
            o_sync <= stage1;
        end
    end

endmodule // svd_sync2

`default_nettype wire

// ### bench/svd_ctrl_asserts.sv
// Port assertions for the supply detector control block
`timescale 1ns/10ps
`default_nettype none
module svd_ctrl_asserts #(parameter ADDR_W = 8) (
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic o_wb_ack,
    input wire logic [7:0] i_opt_byte,
    input wire logic i_cmp_upper,
    input wire logic i_cmp_lower,
    input wire logic [19:0] o_opt_addr,
    input wire logic o_detect_en,
    input wire logic [3:0] o_level_sel,
    input wire logic o_int_reset,
    input wire logic o_supply_level_irq
);
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (i_rst);
    wire [1:0] md = i_opt_byte[5:4];
    chk_ack_pulse: assert property (o_wb_ack |=> !o_wb_ack)
        else $error("ack longer than one cycle");
    chk_ack_answer: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
        else $error("request not answered");
    chk_opt_addr: assert property (o_opt_addr == 20'h000C1)
        else $error("option address wrong");
    chk_level_max: assert property (o_level_sel <= 4'hB)
        else $error("level out of range");
    chk_mode_enable: assert property (!$past(i_rst) && !$past(i_rst, 2) |->
        o_detect_en == (md != 2'h0)) else $error("enable does not match mode");
    chk_off_quiet: assert property (md == 2'h0 && !$past(i_rst) |->
        !o_int_reset && !o_supply_level_irq) else $error("activity with detector off");
    chk_comb_reset: assert property (md == 2'h2 && $rose(o_int_reset) |->
        !$past(i_cmp_lower, 3)) else $error("reset without low crossing");
    chk_comb_release: assert property (md == 2'h2 && $fell(o_int_reset) |->
        $past(i_cmp_upper, 3)) else $error("release below upper");
    chk_comb_irq: assert property (md == 2'h2 && o_supply_level_irq |->
        $past(i_cmp_upper, 4) && !$past(i_cmp_upper, 3)) else $error("bad irq");
    chk_rst_follow: assert property (md == 2'h3 && $past(o_detect_en, 3) |->
        o_int_reset == !$past(i_cmp_upper, 3)) else $error("reset not following");
    chk_irq_hold: assert property (md == 2'h1 && $fell(o_int_reset) |->
        $past(i_cmp_upper, 3)) else $error("early release");
    chk_irq_cross: assert property (md == 2'h1 && o_supply_level_irq |-> !o_int_reset &&
        $past(i_cmp_upper, 3) != $past(i_cmp_upper, 4)) else $error("irq without crossing");
endmodule // svd_ctrl_asserts
bind svd_ctrl svd_ctrl_asserts #(.ADDR_W(ADDR_W)) u_chk (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_wb_cyc(i_wb_cyc),
    .i_wb_stb(i_wb_stb),
    .o_wb_ack(o_wb_ack),
    .i_opt_byte(i_opt_byte),
    .i_cmp_upper(i_cmp_upper),
    .i_cmp_lower(i_cmp_lower),
    .o_opt_addr(o_opt_addr),
    .o_detect_en(o_detect_en),
    .o_level_sel(o_level_sel),
    .o_int_reset(o_int_reset),
    .o_supply_level_irq(o_supply_level_irq)
);
`default_nettype wire

// ### bench/svd_cmp_model.sv
// Comparator pair model on the analog side of the detector
`timescale 1ns/10ps
`default_nettype none
module svd_cmp_model (
    input wire logic [3:0] i_level,
    input wire logic [7:0] i_vdd,
    output logic o_upper,
    output logic o_lower
);
    // Threshold rises with the selected level; lower one sits 16 below
    wire [7:0] up = 8'h40 + {3'h0, i_level, 1'b0};
    assign o_upper = i_vdd >= up;
    assign o_lower = i_vdd >= up - 8'h10;
endmodule // svd_cmp_model
`default_nettype wire

// ### bench/tb_svd_ctrl.sv
// Self-checking bench for the supply detector control block
`timescale 1ns/10ps
`default_nettype none
`include "svd_regs.vh"
module tb_svd_ctrl;
    logic clk = 0, rst = 1, cyc = 0, stb = 0, we = 0;
    logic [7:0] adr = 8'h00, opt = 8'h00, vdd = 8'h00;
    logic [31:0] wdat = 32'h0, rd;
    logic [3:0] sel = 4'hF;
    wire [31:0] rdat;
    wire [19:0] oadr;
    wire [3:0] lvl;
    wire ack, up, lo, den, irst, pls, irq;
    int n_fail = 0, n_compared = 0, npls = 0;
    svd_ctrl DUT (.i_core_clk(clk), .i_rst(rst), .i_wb_cyc(cyc), .i_wb_stb(stb),
        .i_wb_we(we), .i_wb_adr(adr), .i_wb_dat(wdat), .i_wb_sel(sel), .o_wb_dat(rdat),
        .o_wb_ack(ack), .i_opt_byte(opt), .i_cmp_upper(up), .i_cmp_lower(lo),
        .o_opt_addr(oadr), .o_detect_en(den), .o_level_sel(lvl), .o_int_reset(irst),
        .o_supply_level_irq(pls), .o_irq(irq));
    svd_cmp_model u_cmp (.i_level(lvl), .i_vdd(vdd), .o_upper(up), .o_lower(lo));
    initial forever #2 clk = ~clk;
    always @(posedge clk) begin
        if (pls === 1'b1)
            npls <= npls + 1;
    end
    // Reference model of reset request and interrupt pulse, stepped each clock
    int ms = 0, mld = 0;
    logic h1u = 0, h2u = 0, hdu = 0, h1l = 0, h2l = 0, e_irst = 1, e_pls = 0;
    always @(posedge clk) begin
        int nxt;
        logic ev;
        nxt = ms;
        ev = 1'b0;
        if (!rst)
            chk({irst, pls}, {e_irst, e_pls});
        if (ms == 0 && mld == 1 && opt[5:4] != 0)
            nxt = 1;
        else if (ms == 1 && h2u)
            nxt = 2;
        else if (ms == 2 && opt[5:4] == 2) begin
            ev = hdu && !h2u;
            nxt = h2l ? 2 : 1;
        end else if (ms == 2 && opt[5:4] == 3)
            nxt = h2u ? 2 : 1;
        else if (ms == 2 && opt[5:4] == 1)
            ev = hdu != h2u;
        if (rst) begin
            ms <= 0;
            mld <= 0;
            e_irst <= 1'b1;
            e_pls <= 1'b0;
            {h1u, h2u, hdu, h1l, h2l} <= 5'h00;
        end else begin
            ms <= nxt;
            mld <= 1;
            e_irst <= (nxt == 1) || (mld == 0 && opt[5:4] != 0);
            e_pls <= ev;
            {h1u, h2u, hdu, h1l, h2l} <= {up, h1u, h2u, lo, h1l};
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge clk);
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        {cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
        for (n = 0; n < 20; n++) begin
            @(posedge clk);
            if (ack === 1'b1)
                break;
        end
        if (n == 20)
            chk(0, 1);
        rd = rdat;
        {cyc, stb} <= 2'b00;
    endtask
    task automatic finish_test;
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic run(input logic [1:0] m);
        logic [3:0] l, el;
        int p0;
        l = 4'($urandom_range(15));
        el = (l > 4'hB) ? 4'hB : l;
        @(posedge clk);
        rst <= 1'b1;
        opt <= {2'b00, m, l};
        vdd <= 8'h00;
        tick(10);
        rst <= 1'b0;
        tick(2);
        chk(irst, m != 0);
        tick(3);
        p0 = npls;
        chk(lvl, el);
        chk(oadr, 20'h000C1);
        chk(den, m != 0);
        chk(irst, m != 0);
        wb(0, `SVD_ADR_DETECT_CTRL, 0);
        chk({rd[11:8], rd[5:4], rd[0]}, {el, m, m != 0});
        wb(1, `SVD_ADR_IRQ_ENABLE, 32'h3);
        wb(0, `SVD_ADR_IRQ_ENABLE, 0);
        chk(rd[1:0], 2'h3);
        wb(0, 8'h20, 32'h0);
        chk(rd, 0);
        vdd <= 8'hFF;
        tick(6);
        chk(irst, 0);
        chk(npls - p0, 0);
        vdd <= 8'h3C + {3'h0, el, 1'b0};
        tick(6);
        chk(irst, m == 3);
        chk(npls - p0, m == 1 || m == 2);
        vdd <= 8'h00;
        tick(6);
        chk(irst, m >= 2);
        wb(0, `SVD_ADR_RESET_CAUSE, 0);
        chk(rd[0], m >= 2);
        wb(0, `SVD_ADR_RESET_CAUSE, 0);
        chk(rd[0], 0);
        wb(0, `SVD_ADR_IRQ_STATUS, 0);
        chk(rd[1:0], {m >= 2, m == 1 || m == 2});
        chk(irq, m != 0);
        wb(1, `SVD_ADR_IRQ_CLEAR, $urandom | 32'h3);
        tick(2);
        chk(irq, 0);
        vdd <= 8'hFF;
        tick(6);
        chk(irst, 0);
        chk(npls - p0, m == 1 ? 2 : (m == 2 ? 1 : 0));
        chk(irq, m == 1);
        wb(1, `SVD_ADR_IRQ_ENABLE, 32'h0);
        tick(2);
        chk(irq, 0);
        $display("mode %0d test done", m);
    endtask
    initial begin
        #20000;
        chk(0, 1);
        finish_test();
    end
    initial begin
        void'($urandom(14924));
        for (int m = 0; m < 4; m++)
            run(2'(m));
        finish_test();
    end
endmodule // tb_svd_ctrl
`default_nettype wire
